// ### rtl/faconf_regs.sv
// Operation
// - Warn enable bit gates warnings onto fault.
// - Receive power low warning never causes fault.
// - Alarm enable bit gates alarms onto fault.
// - Receive power low alarm never causes fault.
// - Latched warnings clear on read or toggle.
// - Transparent warnings follow condition; read or toggle has no effect.
// - Latched alarms clear on read or toggle.
// - Transparent alarms follow condition; read or toggle has no effect.
// - Start current equals code times 0.375 mA.
// - After fault, loop precharges at start current.
// - Shutdown gate bit isolates shutdown from fault.
// - Table offset bit adds offset to lookup temperature.
// - Result offset bit adds offset to result.
// - Polarity bit selects fault output active level.
// - Multipart bit selects serial multipart mode.
// - Location bit selects password bytes 78h or 7Bh.
// - Timeout bit zero keeps bus timeout active.
// - Configuration survives reset; password needed for access.
`include "faconf_defs.svh"

module faconf_regs
  import faconf_pkg::*;
(
  // Clock and reset
  input  wire logic         core_clk,
  input  wire logic         rst,
  // Byte register port from the serial interface
  input  faconf_req_s       req,
  input  wire logic         password_valid,
  output logic        [7:0] rdata,
  // Monitor conditions and pins
  input  wire logic [15:0]  warn_cond,
  input  wire logic [15:0]  alarm_cond,
  input  wire logic         transmit_disable_in,
  input  wire logic         shutdown_pin_mode,
  // Temperature path
  input  wire logic [15:0]  temp_raw,
  input  wire logic [5:0]   temp_offset,
  output logic      [15:0]  temp_lut,
  output logic      [15:0]  temp_result,
  // Fault and laser loop
  output logic              transmit_fault_out,
  output logic              laser_shutdown_out,
  output logic      [12:0]  start_current_ua,
  output logic              precharge_load,
  // Serial interface options
  output logic              multipart_mode,
  output logic              timeout_active,
  output logic              password_loc_hi
);

  function automatic logic [15:0] add_offset(input logic [15:0] t, input logic [5:0] o,
                                             input logic en);
    add_offset = en ? t + {{10{o[5]}}, o} : t;
  endfunction

  logic [7:0]        word0;
  logic [7:0]        word1;
  faconf_fault_cfg_s fcfg;
  faconf_misc_cfg_s  mcfg;
  logic [15:0]       warn_flags;
  logic [15:0]       alarm_flags;
  logic              dis_meta;
  logic              dis_sync;
  logic              dis_prev;
  logic              fault_int;

  assign fcfg = faconf_fault_cfg_s'(word0);
  assign mcfg = faconf_misc_cfg_s'(word1);

  // Write decode; without a valid password nothing reaches the store.
  wire wr_fault  = req.wr_en && password_valid &&
                   (req.addr == `FACONF_ADDR_FAULT_CFG);
  wire wr_misc   = req.wr_en && password_valid &&
                   (req.addr == `FACONF_ADDR_MISC_CFG);
  wire store_wr  = wr_fault || wr_misc;
  wire store_idx = wr_misc ? `FACONF_IDX_MISC_CFG : `FACONF_IDX_FAULT_CFG;

  faconf_nvstore u_store (
    .core_clk (core_clk),
    .wr_en    (store_wr),
    .wr_idx   (store_idx),
    .wr_data  (req.wdata),
    .word0    (word0),
    .word1    (word1)
  );

  // Read decode and read-to-clear strobes per flag byte.
  wire rd_alarm_hi = req.rd_en && (req.addr == `FACONF_ADDR_ALARM_HI);
  wire rd_alarm_lo = req.rd_en && (req.addr == `FACONF_ADDR_ALARM_LO);
  wire rd_warn_hi  = req.rd_en && (req.addr == `FACONF_ADDR_WARN_HI);
  wire rd_warn_lo  = req.rd_en && (req.addr == `FACONF_ADDR_WARN_LO);
  wire dis_toggle  = dis_sync ^ dis_prev;

  logic [7:0] next_rdata;
  always_comb begin
    if (req.addr == `FACONF_ADDR_FAULT_CFG && password_valid) begin
      next_rdata = word0;
    end else if (req.addr == `FACONF_ADDR_MISC_CFG && password_valid) begin
      next_rdata = word1;
    end else if (req.addr == `FACONF_ADDR_ALARM_HI) begin
      next_rdata = alarm_flags[15:8];
    end else if (req.addr == `FACONF_ADDR_ALARM_LO) begin
      next_rdata = alarm_flags[7:0];
    end else if (req.addr == `FACONF_ADDR_WARN_HI) begin
      next_rdata = warn_flags[15:8];
    end else if (req.addr == `FACONF_ADDR_WARN_LO) begin
      next_rdata = warn_flags[7:0];
    end else begin
      next_rdata = 8'h00;
    end
  end

  wire [15:0] warn_clr  = {{8{rd_warn_hi}}, {8{rd_warn_lo}}} | {16{dis_toggle}};
  wire [15:0] alarm_clr = {{8{rd_alarm_hi}}, {8{rd_alarm_lo}}} | {16{dis_toggle}};

  // A condition present in the clearing cycle keeps its flag set.
  wire [15:0] next_warn_flags = fcfg.warning_transparent ? warn_cond :
                                (warn_flags & ~warn_clr) | warn_cond;
  wire [15:0] next_alarm_flags = fcfg.alarm_transparent ? alarm_cond :
                                 (alarm_flags & ~alarm_clr) | alarm_cond;

  wire warn_any  = |(warn_flags & ~`FACONF_RX_LOW_MASK);
  wire alarm_any = |(alarm_flags & ~`FACONF_RX_LOW_MASK);
  wire next_fault_int = (fcfg.warn_to_fault_en && warn_any) ||
                        (fcfg.alarm_to_fault_en && alarm_any);

  always_ff @(posedge core_clk) begin
    dis_meta <= transmit_disable_in;
    dis_sync <= dis_meta;
    dis_prev <= dis_sync;
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      warn_flags  <= 16'h0000;
      alarm_flags <= 16'h0000;
      fault_int   <= 1'b0;
      rdata       <= 8'h00;
    end else begin
      warn_flags  <= next_warn_flags;
      alarm_flags <= next_alarm_flags;
      fault_int   <= next_fault_int;
      rdata       <= next_rdata;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      transmit_fault_out <= 1'b0;
      laser_shutdown_out <= 1'b0;
      precharge_load     <= 1'b0;
    end else begin
      transmit_fault_out <= fault_int ^ mcfg.fault_active_low;
      laser_shutdown_out <= shutdown_pin_mode && !mcfg.shutdown_gate && fault_int;
      precharge_load     <= fault_int && !next_fault_int;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      start_current_ua <= 13'h0000;
      temp_lut         <= 16'h0000;
      temp_result      <= 16'h0000;
      multipart_mode   <= 1'b0;
      timeout_active   <= 1'b1;
      password_loc_hi  <= 1'b0;
    end else begin
      start_current_ua <= 13'(fcfg.start_current_code) * `FACONF_START_STEP_UA;
      temp_lut         <= add_offset(temp_raw, temp_offset, mcfg.table_offset_en);
      temp_result      <= add_offset(temp_raw, temp_offset, mcfg.result_offset_en);
      multipart_mode   <= mcfg.multipart_en;
      timeout_active   <= !mcfg.timeout_disable;
      password_loc_hi  <= mcfg.password_loc_hi;
    end
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  sequence warn_src_s;
    fcfg.warn_to_fault_en && warn_any;
  endsequence

  sequence alarm_src_s;
    fcfg.alarm_to_fault_en && alarm_any;
  endsequence

  // Fault dropping from one cycle to the next marks a laser restart.
  sequence fault_drop_s;
    fault_int ##1 !fault_int;
  endsequence

  // A read of the low warning byte while its bit 0 condition is gone.
  sequence warn_rd_clr_s;
    !fcfg.warning_transparent && rd_warn_lo && !warn_cond[0];
  endsequence

  // A transmit disable edge while the bit 1 warning condition is gone.
  sequence warn_tog_clr_s;
    !fcfg.warning_transparent && dis_toggle && !warn_cond[1];
  endsequence

  // Reference sum for the offset checks, built from the raw inputs.
  wire [15:0] temp_plus = temp_raw + {{10{temp_offset[5]}}, temp_offset};

  warn_fault_a: assert property (warn_src_s ##1 !$past(rst) |=>
      transmit_fault_out == !$past(mcfg.fault_active_low))
    else $error("enabled warning did not raise fault");

  rxlow_warn_a: assert property ((warn_flags == `FACONF_RX_LOW_MASK) && !alarm_any
      |=> !fault_int)
    else $error("receive power low warning raised fault");

  alarm_fault_a: assert property (alarm_src_s |=> fault_int)
    else $error("enabled alarm did not raise fault");

  no_fault_a: assert property (
      !fcfg.warn_to_fault_en && !fcfg.alarm_to_fault_en |=> !fault_int)
    else $error("fault raised with both sources disabled");

  rxlow_alarm_a: assert property ((alarm_flags == `FACONF_RX_LOW_MASK) && !warn_any
      |=> !fault_int)
    else $error("receive power low alarm raised fault");

  warn_latch_a: assert property (!fcfg.warning_transparent && warn_flags[0] &&
      !warn_clr[0] |=> warn_flags[0])
    else $error("latched warning lost without clear");

  warn_clear_a: assert property (warn_rd_clr_s |=> !warn_flags[0])
    else $error("latched warning not cleared by read");

  warn_toggle_a: assert property (warn_tog_clr_s |=> !warn_flags[1])
    else $error("latched warning not cleared by disable toggle");

  warn_follow_a: assert property (fcfg.warning_transparent |=>
      warn_flags == $past(warn_cond))
    else $error("transparent warning not following condition");

  alarm_clear_a: assert property (!fcfg.alarm_transparent && dis_toggle &&
      !alarm_cond[3] |=> !alarm_flags[3])
    else $error("alarm not cleared by transmit disable toggle");

  alarm_latch_a: assert property (!fcfg.alarm_transparent && alarm_flags[8] &&
      !alarm_clr[8] |=> alarm_flags[8])
    else $error("latched alarm lost without clear");

  alarm_follow_a: assert property (fcfg.alarm_transparent && !alarm_cond[2]
      |=> !alarm_flags[2])
    else $error("transparent alarm stayed set");

  start_cur_a: assert property (1'b1 |=>
      start_current_ua == $past(fcfg.start_current_code) * `FACONF_START_STEP_UA)
    else $error("start current does not match code");

  restart_load_a: assert property (fault_drop_s |-> precharge_load)
    else $error("no precharge load after fault ended");

  load_cause_a: assert property (precharge_load |->
      !fault_int && $past(fault_int))
    else $error("precharge load without fault ending");

  shutdown_gate_a: assert property (mcfg.shutdown_gate |=> !laser_shutdown_out)
    else $error("shutdown driven while gated");

  shutdown_fault_a: assert property (shutdown_pin_mode && !mcfg.shutdown_gate &&
      fault_int |=> laser_shutdown_out)
    else $error("fault did not drive shutdown");

  shutdown_mode_a: assert property (!shutdown_pin_mode |=> !laser_shutdown_out)
    else $error("shutdown driven while pin not in shutdown mode");

  lut_offset_a: assert property (1'b1 |=>
      temp_lut == $past(mcfg.table_offset_en ? temp_plus : temp_raw))
    else $error("lookup temperature offset wrong");

  result_offset_a: assert property (1'b1 |=>
      temp_result == $past(mcfg.result_offset_en ? temp_plus : temp_raw))
    else $error("result temperature offset wrong");

  fault_high_a: assert property (!mcfg.fault_active_low |=>
      transmit_fault_out == $past(fault_int))
    else $error("active high fault level wrong");

  fault_low_a: assert property (mcfg.fault_active_low |=>
      transmit_fault_out != $past(fault_int))
    else $error("active low fault level wrong");

  multipart_a: assert property (1'b1 |=>
      multipart_mode == $past(mcfg.multipart_en))
    else $error("multipart mode does not follow its bit");

  pw_location_a: assert property (1'b1 |=>
      password_loc_hi == $past(mcfg.password_loc_hi))
    else $error("password location does not follow its bit");

  timeout_ctl_a: assert property (1'b1 |=>
      timeout_active != $past(mcfg.timeout_disable))
    else $error("bus timeout does not follow its bit");

  cfg_hidden_a: assert property (!password_valid &&
      (req.addr == `FACONF_ADDR_FAULT_CFG || req.addr == `FACONF_ADDR_MISC_CFG)
      |=> rdata == 8'h00)
    else $error("configuration readable without password");

  nopw_write_a: assert property (!password_valid && req.wr_en ##1 !store_wr [*2]
      |-> $stable(word0) && $stable(word1))
    else $error("store changed without password");

endmodule

// ### rtl/faconf_defs.svh
`ifndef FACONF_DEFS_SVH
`define FACONF_DEFS_SVH

// Byte addresses in the device register space.
`define FACONF_ADDR_FAULT_CFG  8'h19
`define FACONF_ADDR_MISC_CFG   8'h1a
`define FACONF_ADDR_ALARM_HI   8'h70
`define FACONF_ADDR_ALARM_LO   8'h71
`define FACONF_ADDR_WARN_HI    8'h74
`define FACONF_ADDR_WARN_LO    8'h75

// Store word indices.
`define FACONF_IDX_FAULT_CFG   1'b0
`define FACONF_IDX_MISC_CFG    1'b1

// Reset (shipping) values of the nonvolatile words.
`define FACONF_FAULT_CFG_RST   8'h00
`define FACONF_MISC_CFG_RST    8'h00

// Flag vector: bit 6 is the receive power low flag, never a fault source.
`define FACONF_RX_LOW_MASK     16'h0040

// Start current step of 0.375 mA, in microamperes.
`define FACONF_START_STEP_UA   13'h177

`endif

// ### rtl/faconf_pkg.sv
package faconf_pkg;

  typedef struct packed {
    logic       warn_to_fault_en;
    logic       alarm_to_fault_en;
    logic       warning_transparent;
    logic       alarm_transparent;
    logic [3:0] start_current_code;
  } faconf_fault_cfg_s;

  typedef struct packed {
    logic shutdown_gate;
    logic table_offset_en;
    logic result_offset_en;
    logic fault_active_low;
    logic multipart_en;
    logic password_loc_hi;
    logic timeout_disable;
    logic spare;
  } faconf_misc_cfg_s;

  typedef struct packed {
    logic       wr_en;
    logic       rd_en;
    logic [7:0] addr;
    logic [7:0] wdata;
  } faconf_req_s;

endpackage

// ### rtl/faconf_nvstore.sv
`include "faconf_defs.svh"

// Two-word nonvolatile configuration store; contents survive rst.
module faconf_nvstore (
  // Clock
  input  wire logic       core_clk,
  // Write port
  input  wire logic       wr_en,
  input  wire logic       wr_idx,
  input  wire logic [7:0] wr_data,
  // Registered read data
  output logic      [7:0] word0,
  output logic      [7:0] word1
);

  // Programmed image at power-up; rst deliberately does not touch it.
  logic [7:0] mem [0:1] = '{`FACONF_FAULT_CFG_RST, `FACONF_MISC_CFG_RST};

  always_ff @(posedge core_clk) begin
    if (wr_en) begin
      mem[wr_idx] <= wr_data;
    end
    word0 <= mem[0];
    word1 <= mem[1];
  end

endmodule

// ### sim/faconf_host_model.sv
// Host side of the byte register port; drives requests just after the falling edge.
module faconf_host_model
  import faconf_pkg::*;
(
  // Clock
  input  wire logic       core_clk,
  // Register port
  output faconf_req_s     req,
  output logic            password_valid,
  input  wire logic [7:0] rdata
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    req = '0;
    password_valid = 1'b0;
  end

  task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic pw);
    @(negedge core_clk);
    password_valid = pw;
    req = '{wr_en: 1'b1, rd_en: 1'b0, addr: a, wdata: d};
    @(negedge core_clk);
    req.wr_en = 1'b0;
    req.wdata = ~d;
  endtask

  task automatic rd(input logic [7:0] a, input logic pw, output logic [7:0] d);
    @(negedge core_clk);
    password_valid = pw;
    req.addr = a;
    req.rd_en = 1'b1;
    @(negedge core_clk);
    req.rd_en = 1'b0;
    d = rdata;
  endtask
endmodule

// ### sim/test_faconf_regs.sv
module test_faconf_regs
  import faconf_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  typedef struct packed {
    logic [7:0]  f;
    logic [7:0]  m;
    logic [15:0] w;
    logic [15:0] a;
    logic        flt;
    logic        sd;
  } faconf_row_s;

  localparam logic [15:0] TRAW = 16'h0100;
  localparam logic [5:0]  TOFF = 6'h3e;
  localparam logic [15:0] TADJ = TRAW + {{10{TOFF[5]}}, TOFF};
  localparam faconf_row_s ROWS [8] = '{
    '{8'h30, 8'h00, 16'h0001, 16'h0000, 1'b0, 1'b0},
    '{8'hb1, 8'h0e, 16'h0001, 16'h0000, 1'b1, 1'b1},
    '{8'hbf, 8'h60, 16'h0040, 16'h0000, 1'b0, 1'b0},
    '{8'h70, 8'h00, 16'h0000, 16'h0100, 1'b1, 1'b1},
    '{8'h70, 8'h00, 16'h0000, 16'h0040, 1'b0, 1'b0},
    '{8'h70, 8'h80, 16'h0000, 16'h0100, 1'b1, 1'b0},
    '{8'h70, 8'h10, 16'h0000, 16'h0100, 1'b0, 1'b1},
    '{8'h30, 8'h10, 16'h0000, 16'h0000, 1'b1, 1'b0}};

  logic        core_clk = 1'b0;
  logic        rst = 1'b1;
  logic [15:0] warn_cond = 16'h0000;
  logic [15:0] alarm_cond = 16'h0000;
  logic        txd = 1'b0;
  faconf_req_s req;
  logic        password_valid;
  logic [7:0]  rdata;
  logic [7:0]  rd;
  logic [15:0] temp_lut;
  logic [15:0] temp_result;
  logic        fault;
  logic        shut;
  logic        sd_mode = 1'b1;
  logic        prl;
  int          n_pre = 0;
  int          pre0 = 0;
  logic        mp;
  logic        tmo;
  logic        plh;
  logic [12:0] ua;
  int          n_fail = 0;
  int          num_checks = 0;
  int          cyc = 0;

  always #2 core_clk = ~core_clk;

  faconf_regs i_faconf_regs (.core_clk(core_clk), .rst(rst), .req(req),
    .password_valid(password_valid), .rdata(rdata), .warn_cond(warn_cond),
    .alarm_cond(alarm_cond), .transmit_disable_in(txd), .shutdown_pin_mode(sd_mode),
    .temp_raw(TRAW), .temp_offset(TOFF), .temp_lut(temp_lut), .temp_result(temp_result),
    .transmit_fault_out(fault), .laser_shutdown_out(shut), .start_current_ua(ua),
    .precharge_load(prl), .multipart_mode(mp), .timeout_active(tmo), .password_loc_hi(plh));

  faconf_host_model i_faconf_host_model (.core_clk(core_clk), .req(req),
    .password_valid(password_valid), .rdata(rdata));

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic conclude;
    if (n_fail == 0 && num_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic settle;
    repeat (5) @(negedge core_clk);
  endtask

  // A run of about 145 cycles is expected; the ceiling leaves ample margin.
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (prl === 1'b1)
      n_pre <= n_pre + 1;
    if (cyc == 4000) begin
      n_fail++;
      conclude();
    end
  end

  initial begin
    repeat (10) @(negedge core_clk);
    rst = 1'b0;
    foreach (ROWS[i]) begin
      i_faconf_host_model.wr(8'h19, ROWS[i].f, 1'b1);
      i_faconf_host_model.wr(8'h1a, ROWS[i].m, 1'b1);
      warn_cond = ROWS[i].w;
      alarm_cond = ROWS[i].a;
      settle();
      chk(fault, ROWS[i].flt);
      chk(shut, ROWS[i].sd);
      chk(ua, ROWS[i].f[3:0] * 16'd375);
      chk({mp, plh, tmo}, ROWS[i].m[3:1] ^ 3'b001);
      chk(temp_lut, ROWS[i].m[6] ? TADJ : TRAW);
      chk(temp_result, ROWS[i].m[5] ? TADJ : TRAW);
    end
    i_faconf_host_model.rd(8'h19, 1'b0, rd);
    chk(rd, 16'h0000);
    i_faconf_host_model.wr(8'h19, 8'h55, 1'b0);
    settle();
    i_faconf_host_model.rd(8'h19, 1'b1, rd);
    chk(rd, 16'h0030);
    i_faconf_host_model.wr(8'h19, 8'h0c, 1'b1);
    settle();
    rst = 1'b1;
    repeat (3) @(negedge core_clk);
    chk({ua, tmo}, 16'h0001);
    rst = 1'b0;
    settle();
    chk(ua, 16'd4500);
    i_faconf_host_model.wr(8'h19, 8'hc0, 1'b1);
    i_faconf_host_model.wr(8'h1a, 8'h00, 1'b1);
    @(negedge core_clk) warn_cond = 16'h0001;
    @(negedge core_clk) warn_cond = 16'h0000;
    settle();
    chk(fault, 1'b1);
    pre0 = n_pre;
    i_faconf_host_model.rd(8'h75, 1'b1, rd);
    chk(rd, 16'h0001);
    settle();
    chk(fault, 1'b0);
    chk(16'(n_pre - pre0), 16'h0001);
    @(negedge core_clk) alarm_cond = 16'h0100;
    @(negedge core_clk) alarm_cond = 16'h0000;
    settle();
    chk(fault, 1'b1);
    chk(shut, 1'b1);
    sd_mode = 1'b0;
    settle();
    chk(shut, 1'b0);
    pre0 = n_pre;
    txd = 1'b1;
    settle();
    chk(fault, 1'b0);
    chk(16'(n_pre - pre0), 16'h0001);
    conclude();
  end
endmodule
